/* File: verilog/sleep_params.svh */
// Register offsets, field positions, reset values and cycle counts of the sleep controller
`ifndef SLEEP_PARAMS_SVH
`define SLEEP_PARAMS_SVH
`define PCR_ADDR 4'h0
`define STAT_ADDR 4'h1
`define PCR_RESET 8'h00
`define SE_BIT 7
`define SM_HI 6
`define SM_LO 4
`define SENSE1_HI 3
`define SENSE1_LO 2
`define SENSE0_HI 1
`define SENSE0_LO 0
`define HALT_CK 4'h4
`define STANDBY_WAKE_CK 4'h6
`define PD_RESTART_CK 4'h6
`define IDLE_START_CK 4'h1
`endif

/* File: verilog/sleep_pkg.sv */
// Types shared by the sleep controller
package sleep_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_ADCNR = 3'b001,
        MODE_PDOWN = 3'b010,
        MODE_PSAVE = 3'b011,
        MODE_RSVD_A = 3'b100,
        MODE_RSVD_B = 3'b101,
        MODE_STANDBY = 3'b110,
        MODE_RSVD_C = 3'b111
    } sleep_mode_type;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_START = 3'b010,
        ST_HALT = 3'b011
    } state_type;
    // Clock domain and oscillator enables
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic osc;
        logic tosc;
    } clk_gate_type;
    // Enabled interrupt requests from peripherals, same clock
    typedef struct packed {
        logic twi_match;
        logic timer2_irq;
        logic timer2_ie;
        logic global_ie;
        logic timer2_async_select;
        logic spm_ready;
        logic adc_done;
        logic other_io;
    } wake_src_type;
    typedef struct packed {
        logic [7:0] pcr;
        state_type st;
        sleep_mode_type mode;
        logic [3:0] cnt;
        logic rst_flag;
        logic [2:0] sy0;
        logic [2:0] sy1;
        logic [2:0] syr;
        logic [2:0] lvl;
        logic [1:0] prev;
        clk_gate_type gate;
        logic adc_start;
        logic resume;
        logic rvec;
        logic [7:0] rdata;
    } ctl_type;
endpackage : sleep_pkg

/* File: verilog/sleep_mode_controller.sv */
// Sleep mode controller: mode register, sleep entry, clock gating and wake-up sequencing
//
// Overview of operation
// - Sleep only if enable bit set at instruction
// - Mode codes: idle, ADC, down, save, standby
// - Wake by interrupt: four extra halt cycles
// - Register file and SRAM kept while asleep
// - Reset while asleep restarts at reset vector
// - Control register layout, all read/write, zero reset
// - Idle stops only CPU and flash clocks
// - Idle wakes on any enabled interrupt
// - Idle or ADC mode starts ADC conversion
// - ADC mode halts I/O, CPU, flash clocks
// - ADC mode wake sources are restricted
// - Power-down stops oscillator and all clocks
// - Power-down wakes on reset, TWI, level
// - Power-down wake waits clock restart period
// - Power-save also wakes on async timer 2
// - Power-save keeps only async timer clock
// - Standby keeps oscillator, wakes in six cycles
`timescale 1ns/10ps
`include "sleep_params.svh"

module sleep_mode_controller (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic SLEEP_EXEC,
    input wire logic EXT_IRQ_LINE0,
    input wire logic EXT_IRQ_LINE1,
    input wire logic [1:0] EXT_IRQ_EN,
    input wire logic RESET_REQ,
    input wire logic XTAL_SELECTED,
    input wire logic ADC_ENABLED,
    input wire sleep_pkg::wake_src_type WAKE_SRC,
    output sleep_pkg::clk_gate_type CLK_GATE,
    output logic SLEEPING,
    output logic CPU_HALT,
    output logic MEM_HOLD,
    output logic ADC_START,
    output logic IRQ_RESUME,
    output logic RESET_VECTOR
);

    sleep_pkg::ctl_type s;
    sleep_pkg::ctl_type next_s;
    sleep_pkg::sleep_mode_type mode_sel;
    logic [1:0] lvl_req;
    logic [1:0] ext_req;
    logic t2_req;
    logic wake_now;

    // Clock enables for a sleep mode; awake means everything runs except tosc, which follows async_t2
    function automatic sleep_pkg::clk_gate_type gates_for(input sleep_pkg::sleep_mode_type m,
                                                          input logic awake, input logic async_t2);
        sleep_pkg::clk_gate_type g;
        g = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, osc: 1'b1, tosc: async_t2};
        if (!awake) begin
            g.cpu = 1'b0;
            g.flash = 1'b0;
            case (m)
                sleep_pkg::MODE_IDLE: begin
                    g.io = 1'b1;
                end
                sleep_pkg::MODE_ADCNR: begin
                    g.io = 1'b0;
                end
                sleep_pkg::MODE_PSAVE: begin
                    g = '0;
                    g.asy = async_t2;
                    g.tosc = async_t2;
                end
                sleep_pkg::MODE_STANDBY: begin
                    g = '0;
                    g.osc = 1'b1;
                end
                default: begin
                    g = '0;
                end
            endcase
        end
        return g;
    endfunction : gates_for

    // Wake-up counts before the halt phase
    function automatic logic [3:0] startup_for(input sleep_pkg::sleep_mode_type m);
        case (m)
            sleep_pkg::MODE_STANDBY: startup_for = `STANDBY_WAKE_CK - 4'h1;
            sleep_pkg::MODE_PDOWN, sleep_pkg::MODE_PSAVE: startup_for = `PD_RESTART_CK - 4'h1;
            default: startup_for = `IDLE_START_CK - 4'h1;
        endcase
    endfunction : startup_for

    // External line request for a sense setting; low level, any change, falling, rising
    function automatic logic line_req(input logic [1:0] sense, input logic now, input logic was);
        case (sense)
            2'h0: line_req = !now;
            2'h1: line_req = now != was;
            2'h2: line_req = was && !now;
            default: line_req = !was && now;
        endcase
    endfunction : line_req

    // Wake qualification per sleep mode
    always_comb begin
        lvl_req[0] = EXT_IRQ_EN[0] && (s.pcr[`SENSE0_HI:`SENSE0_LO] == 2'h0) && !s.lvl[0];
        lvl_req[1] = EXT_IRQ_EN[1] && (s.pcr[`SENSE1_HI:`SENSE1_LO] == 2'h0) && !s.lvl[1];
        ext_req[0] = EXT_IRQ_EN[0] && line_req(s.pcr[`SENSE0_HI:`SENSE0_LO], s.lvl[0], s.prev[0]);
        ext_req[1] = EXT_IRQ_EN[1] && line_req(s.pcr[`SENSE1_HI:`SENSE1_LO], s.lvl[1], s.prev[1]);
        t2_req = WAKE_SRC.timer2_irq && WAKE_SRC.timer2_ie && WAKE_SRC.global_ie;
        case (s.mode)
            sleep_pkg::MODE_IDLE: begin
                wake_now = (|ext_req) || WAKE_SRC.twi_match || t2_req || WAKE_SRC.spm_ready
                           || WAKE_SRC.adc_done || WAKE_SRC.other_io;
            end
            sleep_pkg::MODE_ADCNR: begin
                wake_now = (|lvl_req) || WAKE_SRC.twi_match || t2_req || WAKE_SRC.spm_ready
                           || WAKE_SRC.adc_done;
            end
            sleep_pkg::MODE_PSAVE: begin
                wake_now = (|lvl_req) || WAKE_SRC.twi_match
                           || (t2_req && WAKE_SRC.timer2_async_select);
            end
            default: begin
                wake_now = (|lvl_req) || WAKE_SRC.twi_match;
            end
        endcase
    end

    // Next state: pin sync, register port, sleep sequencer
    always_comb begin
        next_s = s;
        mode_sel = sleep_pkg::sleep_mode_type'(s.pcr[`SM_HI:`SM_LO]);
        next_s.adc_start = 1'b0;
        next_s.resume = 1'b0;
        next_s.rvec = 1'b0;
        next_s.rdata = 8'h00;
        // Pins pass three flops; a change counts once stages two and three agree
        next_s.sy0 = {s.sy0[1:0], EXT_IRQ_LINE0};
        next_s.sy1 = {s.sy1[1:0], EXT_IRQ_LINE1};
        next_s.syr = {s.syr[1:0], RESET_REQ};
        if (s.sy0[1] == s.sy0[2]) begin
            next_s.lvl[0] = s.sy0[2];
        end
        if (s.sy1[1] == s.sy1[2]) begin
            next_s.lvl[1] = s.sy1[2];
        end
        if (s.syr[1] == s.syr[2]) begin
            next_s.lvl[2] = s.syr[2];
        end
        next_s.prev = s.lvl[1:0];
        // Register port
        if (REG_WR && REG_ADDR == `PCR_ADDR) begin
            next_s.pcr = REG_WDATA;
        end
        if (REG_RD) begin
            case (REG_ADDR)
                `PCR_ADDR: next_s.rdata = s.pcr;
                `STAT_ADDR: next_s.rdata = {1'b0, s.rst_flag, s.st[1:0], 1'b0, s.mode};
                default: next_s.rdata = 8'h00;
            endcase
        end
        // Sleep sequencer
        case (s.st)
            sleep_pkg::ST_RUN: begin
                // Reserved codes never sleep, so a stray code cannot stop the part
                if (SLEEP_EXEC && s.pcr[`SE_BIT] && mode_sel != sleep_pkg::MODE_RSVD_A
                    && mode_sel != sleep_pkg::MODE_RSVD_B && mode_sel != sleep_pkg::MODE_RSVD_C) begin
                    next_s.st = sleep_pkg::ST_SLEEP;
                    next_s.mode = mode_sel;
                    // Standby needs a crystal; without one the oscillator is stopped as well
                    if (mode_sel == sleep_pkg::MODE_STANDBY && !XTAL_SELECTED) begin
                        next_s.mode = sleep_pkg::MODE_PDOWN;
                    end
                    next_s.gate = gates_for(next_s.mode, 1'b0, WAKE_SRC.timer2_async_select);
                    next_s.adc_start = ADC_ENABLED && (mode_sel == sleep_pkg::MODE_IDLE
                                       || mode_sel == sleep_pkg::MODE_ADCNR);
                end else begin
                    next_s.gate = gates_for(s.mode, 1'b1, WAKE_SRC.timer2_async_select);
                end
            end
            sleep_pkg::ST_SLEEP: begin
                next_s.gate = gates_for(s.mode, 1'b0, WAKE_SRC.timer2_async_select);
                if (s.lvl[2] || wake_now) begin
                    next_s.st = sleep_pkg::ST_START;
                    next_s.rst_flag = s.lvl[2];
                    next_s.cnt = startup_for(s.mode);
                    next_s.gate = gates_for(s.mode, 1'b1, WAKE_SRC.timer2_async_select);
                    next_s.gate.cpu = 1'b0;
                    next_s.gate.flash = 1'b0;
                end
            end
            sleep_pkg::ST_START, sleep_pkg::ST_HALT: begin
                if (s.lvl[2]) begin
                    next_s.rst_flag = 1'b1;
                end
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else if (s.st == sleep_pkg::ST_START) begin
                    next_s.st = sleep_pkg::ST_HALT;
                    next_s.cnt = `HALT_CK - 4'h1;
                end else begin
                    next_s.st = sleep_pkg::ST_RUN;
                    next_s.resume = !(s.rst_flag || s.lvl[2]);
                    next_s.rvec = s.rst_flag || s.lvl[2];
                    next_s.rst_flag = 1'b0;
                    next_s.gate = gates_for(s.mode, 1'b1, WAKE_SRC.timer2_async_select);
                end
            end
            default: begin
                next_s.st = sleep_pkg::ST_RUN;
            end
        endcase
    end

    // State register; pins idle high on the interrupt lines
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s <= '0;
            s.pcr <= `PCR_RESET;
            s.sy0 <= 3'h7;
            s.sy1 <= 3'h7;
            s.lvl <= 3'h3;
            s.prev <= 2'h3;
            s.gate <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, osc: 1'b1, tosc: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs; memories are write-inhibited, never cleared, while the core is halted
    assign REG_RDATA = s.rdata;
    assign CLK_GATE = s.gate;
    assign SLEEPING = s.st == sleep_pkg::ST_SLEEP;
    assign CPU_HALT = s.st != sleep_pkg::ST_RUN;
    assign MEM_HOLD = s.st != sleep_pkg::ST_RUN;
    assign ADC_START = s.adc_start;
    assign IRQ_RESUME = s.resume;
    assign RESET_VECTOR = s.rvec;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    chk_sleep_needs_enable: assert property ($rose(SLEEPING) |-> $past(SLEEP_EXEC) && $past(s.pcr[`SE_BIT]))
        else $error("sleep entered without enable bit");
    chk_no_enable_runs: assert property ((s.st == sleep_pkg::ST_RUN && SLEEP_EXEC && !s.pcr[`SE_BIT])
        |=> !SLEEPING [*2])
        else $error("sleep taken with enable bit clear");
    chk_halt_four_cycles: assert property ((s.st == sleep_pkg::ST_HALT && $past(s.st) != sleep_pkg::ST_HALT)
        |-> CPU_HALT [*4] ##1 (IRQ_RESUME || RESET_VECTOR))
        else $error("halt phase not four cycles");
    chk_reset_wake: assert property ((SLEEPING && s.lvl[2]) |=> !SLEEPING ##[1:12] RESET_VECTOR)
        else $error("reset during sleep did not reach reset vector");
    chk_idle_clocks: assert property ((SLEEPING && s.mode == sleep_pkg::MODE_IDLE)
        |-> !CLK_GATE.cpu && !CLK_GATE.flash && CLK_GATE.io && CLK_GATE.adc)
        else $error("idle clock gating wrong");
    chk_adcnr_clocks: assert property ((SLEEPING && s.mode == sleep_pkg::MODE_ADCNR)
        |-> !CLK_GATE.io && !CLK_GATE.cpu && CLK_GATE.adc)
        else $error("ADC mode clock gating wrong");
    chk_pdown_clocks: assert property ((SLEEPING && s.mode == sleep_pkg::MODE_PDOWN) |-> CLK_GATE == '0)
        else $error("power-down left a clock running");
    chk_psave_clocks: assert property ((SLEEPING && s.mode == sleep_pkg::MODE_PSAVE)
        |-> !CLK_GATE.io && !CLK_GATE.osc && CLK_GATE.asy == $past(WAKE_SRC.timer2_async_select))
        else $error("power-save clock gating wrong");
    chk_standby_wake: assert property ((SLEEPING && s.mode == sleep_pkg::MODE_STANDBY && wake_now && !s.lvl[2])
        |-> CLK_GATE.osc ##1 (s.st == sleep_pkg::ST_START) [*6] ##1 s.st == sleep_pkg::ST_HALT)
        else $error("standby wake not six cycles");
    chk_adc_start: assert property (($rose(SLEEPING) && (s.mode == sleep_pkg::MODE_IDLE
        || s.mode == sleep_pkg::MODE_ADCNR) && $past(ADC_ENABLED)) |-> ADC_START)
        else $error("ADC conversion not started");
    chk_pdown_stays: assert property ((SLEEPING && s.mode == sleep_pkg::MODE_PDOWN && !s.lvl[2]
        && !WAKE_SRC.twi_match && lvl_req == 2'h0) |=> SLEEPING)
        else $error("power-down left on a foreign event");
    chk_pcr_write: assert property ((REG_WR && REG_ADDR == `PCR_ADDR) |=> s.pcr == $past(REG_WDATA))
        else $error("control register write lost");

    cov_idle_resume: cover property ($rose(SLEEPING) && s.mode == sleep_pkg::MODE_IDLE ##[1:40] IRQ_RESUME);
    cov_pdown_resume: cover property (SLEEPING && s.mode == sleep_pkg::MODE_PDOWN ##[1:40] IRQ_RESUME);
    cov_reset_wake: cover property (SLEEPING ##[1:40] RESET_VECTOR);

endmodule : sleep_mode_controller

/* File: verif/wake_source_model.sv */
// Far-side model: peripheral wake requests, external lines and reset request
`timescale 1ns/10ps

module wake_source_model (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CPU_HALT,
    input wire logic go,
    input wire logic [3:0] sel,
    output sleep_pkg::wake_src_type wake_src,
    output logic ext_line0,
    output logic ext_line1,
    output logic reset_req
);
    logic [10:0] act;
    logic [10:0] eff;
    logic halt_d;

    // A raised request shows in the same cycle as the strobe
    assign eff = act | (go ? (11'h001 << sel) : 11'h000);
    // Enables held on; async select set, so timer 2 is a legal power-save source
    assign wake_src = {eff[7], eff[6], 3'h7, eff[2], eff[1], eff[0]};
    // Lines idle high; a low level is a request
    assign ext_line0 = ~eff[8];
    assign ext_line1 = ~eff[9];
    assign reset_req = eff[10];

    // Requests held until the CPU resumes, so a level is never lost in the synchroniser
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            act <= 11'h000;
            halt_d <= 1'b0;
        end else begin
            halt_d <= CPU_HALT;
            act <= (halt_d && !CPU_HALT) ? 11'h000 : eff;
        end
    end
endmodule : wake_source_model

/* File: verif/tb_top.sv */
// Testbench for the sleep mode controller
`timescale 1ns/10ps
`include "sleep_params.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
    logic mclk, nrst, reg_wr, reg_rd, sleep_exec, xtal_selected, adc_enabled, go;
    logic [3:0] reg_addr, sel;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [1:0] ext_irq_en;
    logic ext0, ext1, reset_req, sleeping, cpu_halt, mem_hold, adc_start, irq_resume, reset_vector;
    sleep_pkg::wake_src_type wake_src;
    sleep_pkg::clk_gate_type clk_gate;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    // Mode table: code, running clocks cpu..osc, refused source, waking source
    logic [2:0] mode_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
    logic [5:0] gate_tab [5] = '{6'h0f, 6'h07, 6'h00, 6'h02, 6'h01};
    logic [3:0] forbid_tab [5] = '{4'hf, 4'h0, 4'h6, 4'h2, 4'h6};
    logic [3:0] wake_tab [5] = '{4'h0, 4'h1, 4'h7, 4'h6, 4'h7};

    sleep_mode_controller u_sleep_mode_controller (
        .MCLK(mclk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SLEEP_EXEC(sleep_exec), .EXT_IRQ_LINE0(ext0),
        .EXT_IRQ_LINE1(ext1), .EXT_IRQ_EN(ext_irq_en), .RESET_REQ(reset_req),
        .XTAL_SELECTED(xtal_selected), .ADC_ENABLED(adc_enabled), .WAKE_SRC(wake_src),
        .CLK_GATE(clk_gate), .SLEEPING(sleeping), .CPU_HALT(cpu_halt), .MEM_HOLD(mem_hold),
        .ADC_START(adc_start), .IRQ_RESUME(irq_resume), .RESET_VECTOR(reset_vector)
    );

    wake_source_model u_wake_source_model (
        .MCLK(mclk), .NRST(nrst), .CPU_HALT(cpu_halt), .go(go), .sel(sel), .wake_src(wake_src),
        .ext_line0(ext0), .ext_line1(ext1), .reset_req(reset_req)
    );

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Verdict and end of run, reached from the sequence and the hang guard
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic do_sleep();
        @(posedge mclk);
        sleep_exec <= 1'b1;
        @(posedge mclk);
        sleep_exec <= 1'b0;
        #1;
    endtask : do_sleep

    task automatic raise(input logic [3:0] s);
        @(posedge mclk);
        go <= 1'b1;
        sel <= s;
        @(posedge mclk);
        go <= 1'b0;
    endtask : raise

    // Raise a source, count edges to the resume pulse; exp_n of 0 skips the count
    task automatic wake(input logic [3:0] s, input int exp_n, input logic exp_rv);
        int n;
        n = 0;
        @(posedge mclk);
        go <= 1'b1;
        sel <= s;
        repeat (60) begin
            @(posedge mclk);
            go <= 1'b0;
            #1;
            n++;
            if (irq_resume || reset_vector) break;
        end
        if (exp_n > 0) `CHK("wake cycles", exp_n, n)
        `CHK("reset vector", exp_rv, reset_vector)
        `CHK("resume", !exp_rv, irq_resume)
        `CHK("halt at resume", 1'b0, cpu_halt)
        @(posedge mclk);
        #1;
        `CHK("pulse length", 2'b00, {irq_resume, reset_vector})
    endtask : wake

    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, sleep_exec, go} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        sel = 4'h0;
        ext_irq_en = 2'h3;
        xtal_selected = 1'b1;
        adc_enabled = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        `CHK("gates in reset", 7'h7e, clk_gate)
        nrst <= 1'b1;
        // Register reset value, read/write, unmapped place
        rd(`PCR_ADDR, d);
        `CHK("control reset", `PCR_RESET, d)
        wr(`PCR_ADDR, 8'hff);
        rd(`PCR_ADDR, d);
        `CHK("control rw", 8'hff, d)
        rd(4'hf, d);
        `CHK("unmapped", 8'h00, d)
        $display("Test ended: registers");
        // Sleep instruction with enable clear, then reserved codes 4 and 5
        wr(`PCR_ADDR, 8'h20);
        do_sleep();
        `CHK("no sleep enable off", 1'b0, cpu_halt)
        for (int r = 4; r < 6; r++) begin
            wr(`PCR_ADDR, {1'b1, 3'(r), 4'h0});
            do_sleep();
            `CHK("reserved mode", 1'b0, sleeping)
        end
        $display("Test ended: refused sleep");
        // Every mode: clocks, conversion start, accepted wake source; a refused source in every mode but idle
        for (int i = 0; i < 5; i++) begin
            wr(`PCR_ADDR, {1'b1, mode_tab[i], 4'h0});
            do_sleep();
            `CHK("sleeping", 1'b1, sleeping)
            `CHK("clock gates", gate_tab[i], clk_gate[6:1])
            `CHK("adc start", (i < 2), adc_start)
            `CHK("memory hold", 1'b1, mem_hold)
            rd(4'(`STAT_ADDR), d);
            `CHK("status", {2'h1, mode_tab[i]}, {d[5:4], d[2:0]})
            if (forbid_tab[i] != 4'hf) begin
                raise(forbid_tab[i]);
                repeat (10) @(posedge mclk);
                #1;
                `CHK("refused source", 1'b1, sleeping)
            end
            wake(wake_tab[i], (i < 2 ? `IDLE_START_CK : `PD_RESTART_CK) + `HALT_CK + 1, 1'b0);
            rd(`PCR_ADDR, d);
            `CHK("control kept", {1'b1, mode_tab[i], 4'h0}, d)
        end
        $display("Test ended: modes");
        // Crystal missing falls back to power-down; converter off gives no start; edge sense in idle
        xtal_selected <= 1'b0;
        adc_enabled <= 1'b0;
        wr(`PCR_ADDR, 8'he0);
        do_sleep();
        `CHK("standby no crystal", 6'h00, clk_gate[6:1])
        wake(4'h7, `PD_RESTART_CK + `HALT_CK + 1, 1'b0);
        wr(`PCR_ADDR, 8'h82);
        do_sleep();
        `CHK("adc off no start", 1'b0, adc_start)
        wake(4'h8, 0, 1'b0);
        xtal_selected <= 1'b1;
        $display("Test ended: options");
        // Level wake on each external line, then reset while asleep
        for (int k = 8; k < 11; k++) begin
            wr(`PCR_ADDR, 8'ha0);
            do_sleep();
            wake(4'(k), 0, (k == 10));
        end
        $display("Test ended: level and reset wake");
        stop_test();
    end
endmodule : tb_top
